// ---- common/rcs_pkg.sv ----
// Constants and types shared by the reset cause and state controller
package rcs_pkg;

  localparam int ADDR_W = 8;

  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_WATCHDOG_CONTROL     = 8'h04;
  localparam logic [7:0] OFF_LOW_VOLTAGE_RESET_SELECT     = 8'h08;
  localparam logic [7:0] OFF_CTRL     = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_WATCHDOG_CONTROL   = 8'h53;
  localparam logic [7:0] RST_LOW_VOLTAGE_RESET_SELECT   = 8'h55;

  localparam int STAT_TO_BIT     = 5;
  localparam int STAT_PDF_BIT    = 4;
  localparam int CTRL_FSYSON_BIT = 7;
  localparam int CTRL_FSUBF_BIT  = 3;
  localparam int CTRL_LOW_VOLTAGE_RESET_FLAG_BIT   = 2;
  localparam int CTRL_LRF_BIT    = 1;
  localparam int CTRL_WRF_BIT    = 0;

  localparam int         WDT_EN_LSB   = 3;
  localparam logic [4:0] WDT_CODE_ON  = 5'h0a;
  localparam logic [4:0] WDT_CODE_OFF = 5'h15;

  localparam logic [7:0] LVR_SEL_A = 8'h55;
  localparam logic [7:0] LVR_SEL_B = 8'h33;
  localparam logic [7:0] LVR_SEL_C = 8'h99;
  localparam logic [7:0] LVR_SEL_D = 8'haa;

  localparam int IRQ_W        = 4;
  localparam int IRQ_LVR_BIT  = 0;
  localparam int IRQ_WDTN_BIT = 1;
  localparam int IRQ_WDTS_BIT = 2;
  localparam int IRQ_CFG_BIT  = 3;

  localparam int CLK_PERIOD_NS = 20;
  localparam int T_LVR_NS      = 40000;
  localparam int SYSTEM_START_DELAY_NS      = 20480;
  localparam int T_SRESET_NS   = 10000;
  localparam int LVR_QUAL_CYC  = (T_LVR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CYC     = (SYSTEM_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRESET_CYC    = (T_SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    K_POR  = 3'b000,
    K_LVR  = 3'b001,
    K_WDTN = 3'b010,
    K_WDTS = 3'b011,
    K_CFGW = 3'b100,
    K_CFGL = 3'b101
  } rcs_kind_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_APPLY = 2'b01,
    ST_START = 2'b10
  } rcs_state_t;

  typedef struct packed {
    logic pcZero;
    logic spTop;
    logic spZero;
    logic intOff;
    logic timersOff;
    logic portsIn;
    logic wdtClear;
    logic timeBaseClear;
  } rcs_action_t;

  localparam rcs_action_t ACT_NONE  = rcs_action_t'(8'h00);
  localparam rcs_action_t ACT_FULL  = rcs_action_t'(8'hdf);
  localparam rcs_action_t ACT_SLEEP = rcs_action_t'(8'ha0);

endpackage : rcs_pkg

// ---- rtl/rcs_qualify.sv ----
// Level qualifier: reports a level only after it has stood long enough
`timescale 1ns/1ps
module rcs_qualify #(
  parameter int CYC = 4
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic level,
  output logic      qualified
);
  localparam int            CW  = $clog2(CYC + 1);
  localparam logic [CW-1:0] TOP = CW'(CYC - 1);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (sys_rst || !level) begin
      cnt_reg   <= '0;
      qualified <= 1'b0;
    end else if (cnt_reg == TOP) begin
      qualified <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule : rcs_qualify

// ---- rtl/rcs_start_timer.sv ----
// Start-up delay timer: busy for a fixed number of cycles after a start pulse
`timescale 1ns/1ps
module rcs_start_timer #(
  parameter int CYC = 4
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy
);
  localparam int            CW  = $clog2(CYC + 1);
  localparam logic [CW-1:0] TOP = CW'(CYC - 1);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      busy    <= 1'b0;
    end else if (start) begin
      cnt_reg <= '0;
      busy    <= 1'b1;
    end else if (busy) begin
      cnt_reg <= cnt_reg + 1'b1;
      busy    <= (cnt_reg != TOP);
    end
  end

endmodule : rcs_start_timer

// ---- rtl/rcs_reset_control.sv ----
// Reset cause and state controller with APB register access
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - A watchdog time-out in normal running issues the same full reset action as a low-voltage reset and also sets the time-out flag.
// - A watchdog time-out in sleep or idle clears only the program counter and stack pointer and sets the time-out flag.
// - Power-on reset clears both the time-out flag and the power-down flag.
// - A low-voltage reset in normal or slow running leaves the time-out and power-down flags as they were.
// - A watchdog time-out reset in normal or slow running sets the time-out flag and keeps the power-down flag.
// - A watchdog time-out reset in sleep or idle leaves both the time-out and power-down flags at one.
// - After power-on reset every interrupt source is disabled until software enables it.
// - After power-on reset the watchdog and time-base counters are cleared and the watchdog starts counting at once.
// - After power-on reset all timer modules are switched off.
// - After power-on reset every general-purpose port pin is an input.
// - After power-on reset the stack pointer points at the top of the hardware stack.
// - A qualified low-voltage condition resets the device and sets the low-voltage flag, which only software clears.
module rcs_reset_control #(
  parameter int LVR_CYC    = rcs_pkg::LVR_QUAL_CYC,
  parameter int SST_CYC    = rcs_pkg::START_CYC,
  parameter int SRESET_CYC = rcs_pkg::SRESET_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [rcs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       lowVoltage,
  input  wire logic                       wdtTimeout,
  input  wire logic                       sleepMode,
  input  wire logic                       haltEnter,
  input  wire logic                       clrWdt,
  output rcs_pkg::rcs_action_t            resetAction,
  output logic                            coreHold,
  output logic                            wdtRun,
  output logic      [7:0]                 lvrSelect,
  output logic                            irq
);

  function automatic logic isReg(input logic [rcs_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] off);
    isReg = (a == off);
  endfunction : isReg

  function automatic logic lvrcBad(input logic [7:0] v);
    lvrcBad = !(v == rcs_pkg::LVR_SEL_A || v == rcs_pkg::LVR_SEL_B ||
                v == rcs_pkg::LVR_SEL_C || v == rcs_pkg::LVR_SEL_D);
  endfunction : lvrcBad

  function automatic logic wdtcBad(input logic [7:0] v);
    logic [4:0] we;
    we      = v[rcs_pkg::WDT_EN_LSB +: 5];
    wdtcBad = (we != rcs_pkg::WDT_CODE_ON) && (we != rcs_pkg::WDT_CODE_OFF);
  endfunction : wdtcBad

  rcs_pkg::rcs_state_t     state_reg;
  rcs_pkg::rcs_kind_t      kind_reg;
  logic                    to_reg;
  logic                    pdf_reg;
  logic [7:0]              statusOther_reg;
  logic [7:0]              watchdog_control_reg;
  logic [7:0]              low_voltage_reset_select_reg;
  logic                    fsysOn_reg;
  logic                    fsubf_reg;
  logic                    low_voltage_reset_flag_reg;
  logic                    lrf_reg;
  logic                    wrf_reg;
  logic [rcs_pkg::IRQ_W-1:0] irqStat_reg;
  logic [rcs_pkg::IRQ_W-1:0] irqMask_reg;
  logic [rcs_pkg::IRQ_W-1:0] irqSet;

  logic        lvrOk;
  logic        lvrcBadOk;
  logic        wdtcBadOk;
  logic        startBusy;
  logic        apply;
  logic        fullKind;
  logic        access;
  logic        wrAcc;
  logic        mapped;
  logic [31:0] readValue;

  rcs_qualify #(.CYC(LVR_CYC)) u_lvrQual (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .level     (lowVoltage && !sleepMode),
    .qualified (lvrOk)
  );

  rcs_qualify #(.CYC(SRESET_CYC)) u_lvrcQual (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .level     (lvrcBad(low_voltage_reset_select_reg)),
    .qualified (lvrcBadOk)
  );

  rcs_qualify #(.CYC(SRESET_CYC)) u_wdtcQual (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .level     (wdtcBad(watchdog_control_reg)),
    .qualified (wdtcBadOk)
  );

  rcs_start_timer #(.CYC(SST_CYC)) u_start (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (apply),
    .busy    (startBusy)
  );

  assign apply    = (state_reg == rcs_pkg::ST_APPLY);
  assign fullKind = (kind_reg != rcs_pkg::K_WDTS);
  assign access   = psel && penable && pready;
  assign wrAcc    = access && pwrite;
  assign mapped   = isReg(paddr, rcs_pkg::OFF_STATUS) || isReg(paddr, rcs_pkg::OFF_WATCHDOG_CONTROL) ||
                    isReg(paddr, rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT) || isReg(paddr, rcs_pkg::OFF_CTRL) ||
                    isReg(paddr, rcs_pkg::OFF_IRQ_STAT) || isReg(paddr, rcs_pkg::OFF_IRQ_MASK);

  // Reset sequencing; power-on enters the apply step straight from reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= rcs_pkg::ST_APPLY;
      kind_reg  <= rcs_pkg::K_POR;
    end else begin
      case (state_reg)
        rcs_pkg::ST_RUN: begin
          if (lvrOk) begin
            state_reg <= rcs_pkg::ST_APPLY;
            kind_reg  <= rcs_pkg::K_LVR;
          end else if (lvrcBadOk) begin
            state_reg <= rcs_pkg::ST_APPLY;
            kind_reg  <= rcs_pkg::K_CFGL;
          end else if (wdtcBadOk) begin
            state_reg <= rcs_pkg::ST_APPLY;
            kind_reg  <= rcs_pkg::K_CFGW;
          end else if (wdtTimeout) begin
            state_reg <= rcs_pkg::ST_APPLY;
            kind_reg  <= sleepMode ? rcs_pkg::K_WDTS : rcs_pkg::K_WDTN;
          end
        end
        rcs_pkg::ST_APPLY: begin
          state_reg <= rcs_pkg::ST_START;
        end
        rcs_pkg::ST_START: begin
          if (!startBusy) begin
            state_reg <= rcs_pkg::ST_RUN;
          end
        end
        default: begin
          state_reg <= rcs_pkg::ST_RUN;
        end
      endcase
    end
  end

  // One-cycle action strobe to core, timers, ports and watchdog
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resetAction <= rcs_pkg::ACT_NONE;
    end else if (apply && fullKind) begin
      resetAction <= rcs_pkg::ACT_FULL;
    end else if (apply) begin
      resetAction <= rcs_pkg::ACT_SLEEP;
    end else begin
      resetAction <= rcs_pkg::ACT_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      coreHold <= 1'b1;
      wdtRun   <= 1'b0;
    end else begin
      coreHold <= (state_reg != rcs_pkg::ST_RUN);
      wdtRun   <= (watchdog_control_reg[rcs_pkg::WDT_EN_LSB +: 5] == rcs_pkg::WDT_CODE_ON);
    end
  end

  // Time-out flag: set by either watchdog time-out reset (not the control-code reset), cleared by the watchdog clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      to_reg <= 1'b0;
    end else if (apply && (kind_reg == rcs_pkg::K_WDTN || kind_reg == rcs_pkg::K_WDTS)) begin
      to_reg <= 1'b1;
    end else if (clrWdt) begin
      to_reg <= 1'b0;
    end
  end

  // Power-down flag: set on halt and on a sleep time-out, kept by full resets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pdf_reg <= 1'b0;
    end else if (haltEnter || (apply && kind_reg == rcs_pkg::K_WDTS)) begin
      pdf_reg <= 1'b1;
    end else if (clrWdt) begin
      pdf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      statusOther_reg <= rcs_pkg::RST_STATUS;
    end else if (wrAcc && isReg(paddr, rcs_pkg::OFF_STATUS)) begin
      statusOther_reg <= pwdata[7:0];
    end
  end

  // Configuration registers return to their power-on values on full resets
  always_ff @(posedge clk) begin
    if (sys_rst || (apply && fullKind)) begin
      watchdog_control_reg <= rcs_pkg::RST_WATCHDOG_CONTROL;
      low_voltage_reset_select_reg <= rcs_pkg::RST_LOW_VOLTAGE_RESET_SELECT;
    end else begin
      if (wrAcc && isReg(paddr, rcs_pkg::OFF_WATCHDOG_CONTROL)) begin
        watchdog_control_reg <= pwdata[7:0];
      end
      if (wrAcc && isReg(paddr, rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT)) begin
        low_voltage_reset_select_reg <= pwdata[7:0];
      end
    end
  end

  assign lvrSelect = low_voltage_reset_select_reg;

  always_ff @(posedge clk) begin
    if (sys_rst || (apply && fullKind)) begin
      fsysOn_reg <= 1'b0;
    end else if (wrAcc && isReg(paddr, rcs_pkg::OFF_CTRL)) begin
      fsysOn_reg <= pwdata[rcs_pkg::CTRL_FSYSON_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fsubf_reg <= 1'b0;
    end else if (wrAcc && isReg(paddr, rcs_pkg::OFF_CTRL)) begin
      fsubf_reg <= pwdata[rcs_pkg::CTRL_FSUBF_BIT];
    end
  end

  // Cause flags: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_voltage_reset_flag_reg <= 1'b0;
      lrf_reg  <= 1'b0;
      wrf_reg  <= 1'b0;
    end else begin
      low_voltage_reset_flag_reg <= (apply && kind_reg == rcs_pkg::K_LVR) ||
                  (low_voltage_reset_flag_reg && !(wrAcc && isReg(paddr, rcs_pkg::OFF_CTRL) &&
                                 !pwdata[rcs_pkg::CTRL_LOW_VOLTAGE_RESET_FLAG_BIT]));
      lrf_reg  <= (apply && kind_reg == rcs_pkg::K_CFGL) ||
                  (lrf_reg && !(wrAcc && isReg(paddr, rcs_pkg::OFF_CTRL) &&
                                !pwdata[rcs_pkg::CTRL_LRF_BIT]));
      wrf_reg  <= (apply && kind_reg == rcs_pkg::K_CFGW) ||
                  (wrf_reg && !(wrAcc && isReg(paddr, rcs_pkg::OFF_CTRL) &&
                                !pwdata[rcs_pkg::CTRL_WRF_BIT]));
    end
  end

  // Interrupt status and mask
  always_comb begin
    irqSet = '0;
    irqSet[rcs_pkg::IRQ_LVR_BIT]  = apply && kind_reg == rcs_pkg::K_LVR;
    irqSet[rcs_pkg::IRQ_WDTN_BIT] = apply && kind_reg == rcs_pkg::K_WDTN;
    irqSet[rcs_pkg::IRQ_WDTS_BIT] = apply && kind_reg == rcs_pkg::K_WDTS;
    irqSet[rcs_pkg::IRQ_CFG_BIT]  = apply && (kind_reg == rcs_pkg::K_CFGL ||
                                              kind_reg == rcs_pkg::K_CFGW);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStat_reg <= '0;
    end else if (wrAcc && isReg(paddr, rcs_pkg::OFF_IRQ_STAT)) begin
      irqStat_reg <= (irqStat_reg & ~pwdata[rcs_pkg::IRQ_W-1:0]) | irqSet;
    end else begin
      irqStat_reg <= irqStat_reg | irqSet;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqMask_reg <= '0;
    end else if (wrAcc && isReg(paddr, rcs_pkg::OFF_IRQ_MASK)) begin
      irqMask_reg <= pwdata[rcs_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end

  // APB read mux and one-wait-state answer
  always_comb begin
    readValue = '0;
    case (paddr)
      rcs_pkg::OFF_STATUS: begin
        readValue[7:0] = statusOther_reg;
        readValue[rcs_pkg::STAT_TO_BIT]  = to_reg;
        readValue[rcs_pkg::STAT_PDF_BIT] = pdf_reg;
      end
      rcs_pkg::OFF_WATCHDOG_CONTROL: readValue[7:0] = watchdog_control_reg;
      rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT: readValue[7:0] = low_voltage_reset_select_reg;
      rcs_pkg::OFF_CTRL: begin
        readValue[rcs_pkg::CTRL_FSYSON_BIT] = fsysOn_reg;
        readValue[rcs_pkg::CTRL_FSUBF_BIT]  = fsubf_reg;
        readValue[rcs_pkg::CTRL_LOW_VOLTAGE_RESET_FLAG_BIT]   = low_voltage_reset_flag_reg;
        readValue[rcs_pkg::CTRL_LRF_BIT]    = lrf_reg;
        readValue[rcs_pkg::CTRL_WRF_BIT]    = wrf_reg;
      end
      rcs_pkg::OFF_IRQ_STAT: readValue[rcs_pkg::IRQ_W-1:0] = irqStat_reg;
      rcs_pkg::OFF_IRQ_MASK: readValue[rcs_pkg::IRQ_W-1:0] = irqMask_reg;
      default: readValue = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= readValue;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  porFlags_clear_a: assert property ($fell(sys_rst) |-> !to_reg && !pdf_reg)
    else $error("flags not clear after power-on reset");

  porAction_full_a: assert property ($fell(sys_rst) |=> resetAction == rcs_pkg::ACT_FULL
                                     && coreHold)
    else $error("power-on reset did not issue full action");

  lvrFlags_keep_a: assert property (apply && kind_reg == rcs_pkg::K_LVR && !haltEnter &&
                                    !clrWdt |=> $stable(to_reg) && $stable(pdf_reg))
    else $error("low-voltage reset changed a status flag");

  wdtNormal_act_a: assert property (apply && kind_reg == rcs_pkg::K_WDTN |=>
                                    to_reg && resetAction == rcs_pkg::ACT_FULL
                                    && watchdog_control_reg == rcs_pkg::RST_WATCHDOG_CONTROL)
    else $error("normal watchdog reset wrong");

  wdtSleep_act_a: assert property (apply && kind_reg == rcs_pkg::K_WDTS |=>
                                   to_reg && pdf_reg &&
                                   resetAction == rcs_pkg::ACT_SLEEP)
    else $error("sleep watchdog reset wrong");

  lvrFlag_set_a: assert property (state_reg == rcs_pkg::ST_RUN && lvrOk |=>
                                  apply ##1 low_voltage_reset_flag_reg && resetAction.pcZero)
    else $error("low-voltage flag not set");

  sleepOnly_pcsp_a: assert property (wdtTimeout && sleepMode && state_reg == rcs_pkg::ST_RUN
                                     && !lvrOk && !lvrcBadOk && !wdtcBadOk
                                     |=> ##1 !resetAction.intOff && resetAction.spZero)
    else $error("sleep time-out disturbed peripherals");

  hold_after_apply_a: assert property (apply |=> coreHold [*2])
    else $error("core not held after reset action");

  irq_level_a: assert property (##1 irq == |($past(irqStat_reg) & $past(irqMask_reg)))
    else $error("interrupt output mismatch");

  apb_ready_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle");

endmodule : rcs_reset_control

// ---- bench/rcs_partner_model.sv ----
// Behavioural watchdog, supply monitor and core facing the reset controller
`timescale 1ns/1ps
module rcs_partner_model (
  input  wire logic clk,
  output logic      lowVoltage,
  output logic      wdtTimeout,
  output logic      sleepMode,
  output logic      haltEnter,
  output logic      clrWdt
);
  initial begin
    lowVoltage = 1'b0;
    wdtTimeout = 1'b0;
    sleepMode  = 1'b0;
    haltEnter  = 1'b0;
    clrWdt     = 1'b0;
  end

  // Watchdog overflow, one cycle, with the core asleep or awake
  task automatic wdt_pulse(input logic asleep);
    sleepMode  <= asleep;
    wdtTimeout <= 1'b1;
    @(posedge clk);
    wdtTimeout <= 1'b0;
  endtask : wdt_pulse

  // Core instruction pulse: power-down entry or watchdog clear
  task automatic core_pulse(input logic halt);
    if (halt) begin
      haltEnter <= 1'b1;
    end else begin
      clrWdt <= 1'b1;
    end
    @(posedge clk);
    if (halt) begin
      haltEnter <= 1'b0;
    end else begin
      clrWdt <= 1'b0;
    end
  endtask : core_pulse

  task automatic supply_low(input int cyc);
    lowVoltage <= 1'b1;
    repeat (cyc) @(posedge clk);
    lowVoltage <= 1'b0;
  endtask : supply_low

  task automatic wake();
    sleepMode <= 1'b0;
  endtask : wake
endmodule : rcs_partner_model

// ---- bench/reset_cause_state_control_bench.sv ----
// Self-checking bench for the reset cause and state controller
`timescale 1ns/1ps
module reset_cause_state_control_bench;
  localparam int LVR_C = 4;
  localparam int SST_C = 6;
  localparam int SRS_C = 5;

  logic                       clk;
  logic                       sys_rst;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [rcs_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic                       lowVoltage;
  logic                       wdtTimeout;
  logic                       sleepMode;
  logic                       haltEnter;
  logic                       clrWdt;
  rcs_pkg::rcs_action_t       resetAction;
  logic                       coreHold;
  logic                       wdtRun;
  logic [7:0]                 lvrSelect;
  logic                       irq;
  int                         err_total;
  int                         comparisons;
  int                         seed;
  logic [31:0]                rdat;
  logic                       rerr;
  logic [7:0]                 statusM;
  logic [7:0]                 ctrlM;
  logic [7:0]                 irqM;
  logic [7:0]                 rnd;

  rcs_reset_control #(.LVR_CYC(LVR_C), .SST_CYC(SST_C), .SRESET_CYC(SRS_C)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lowVoltage(lowVoltage), .wdtTimeout(wdtTimeout), .sleepMode(sleepMode),
    .haltEnter(haltEnter), .clrWdt(clrWdt), .resetAction(resetAction),
    .coreHold(coreHold), .wdtRun(wdtRun), .lvrSelect(lvrSelect), .irq(irq)
  );

  rcs_partner_model u_partner (
    .clk(clk), .lowVoltage(lowVoltage), .wdtTimeout(wdtTimeout),
    .sleepMode(sleepMode), .haltEnter(haltEnter), .clrWdt(clrWdt)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'($random(seed)), d[7:0]};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, {24'h0, exp});
    check({31'h0, rerr}, 32'h0);
  endtask : rd

  // Waits for the reset pulse, optionally fires a watchdog during hold
  task automatic await_reset(input rcs_pkg::rcs_action_t exp, input logic refuse);
    int n;
    n = 0;
    while (resetAction === rcs_pkg::ACT_NONE && n < 60) begin
      @(posedge clk);
      n++;
    end
    check(32'(resetAction), 32'(exp));
    if (refuse) begin
      u_partner.wdt_pulse(1'b0);
    end
    n = 0;
    while (coreHold !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, coreHold}, 32'h0);
    @(posedge clk);
  endtask : await_reset

  task automatic quiet(input int cyc);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (resetAction !== rcs_pkg::ACT_NONE) hits++;
    end
    check(hits, 0);
  endtask : quiet

  initial begin
    #(20 * 20000);
    err_total++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    comparisons = 0;
    seed = 32'hca93e44d;
    statusM = rcs_pkg::RST_STATUS;
    ctrlM = 8'h00;
    irqM = 8'h00;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    await_reset(rcs_pkg::ACT_FULL, 1'b0);
    check({31'h0, wdtRun}, 32'h1);
    rd(rcs_pkg::OFF_STATUS, statusM);
    rd(rcs_pkg::OFF_WATCHDOG_CONTROL, rcs_pkg::RST_WATCHDOG_CONTROL);
    rd(rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT, rcs_pkg::RST_LOW_VOLTAGE_RESET_SELECT);
    rd(rcs_pkg::OFF_CTRL, ctrlM);
    rd(rcs_pkg::OFF_IRQ_MASK, 8'h00);
    apb(1'b0, 8'h20, 32'h0);
    check(rdat, 32'h0);
    check({31'h0, rerr}, 32'h1);
    repeat (4) begin
      rnd = 8'($random(seed));
      apb(1'b1, rcs_pkg::OFF_STATUS, {24'h0, rnd});
      statusM = (statusM & 8'h30) | (rnd & 8'hcf);
      rd(rcs_pkg::OFF_STATUS, statusM);
    end
    // Watchdog overflow while asleep keeps register contents
    apb(1'b1, rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT, {24'h0, rcs_pkg::LVR_SEL_B});
    u_partner.core_pulse(1'b1);
    statusM = statusM | 8'h10;
    u_partner.wdt_pulse(1'b1);
    await_reset(rcs_pkg::ACT_SLEEP, 1'b0);
    u_partner.wake();
    statusM = statusM | 8'h30;
    irqM = irqM | 8'h04;
    rd(rcs_pkg::OFF_STATUS, statusM);
    rd(rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT, rcs_pkg::LVR_SEL_B);
    check({24'h0, lvrSelect}, {24'h0, rcs_pkg::LVR_SEL_B});
    // Overflow while running: full reset, time-out set, power-down kept
    apb(1'b1, rcs_pkg::OFF_CTRL, 32'h88);
    ctrlM = 8'h88;
    u_partner.core_pulse(1'b0);
    u_partner.core_pulse(1'b1);
    statusM = (statusM & 8'hcf) | 8'h10;
    u_partner.wdt_pulse(1'b0);
    await_reset(rcs_pkg::ACT_FULL, 1'b1);
    quiet(12);
    statusM = statusM | 8'h20;
    ctrlM = ctrlM & 8'h0f;
    irqM = irqM | 8'h02;
    rd(rcs_pkg::OFF_STATUS, statusM);
    rd(rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT, rcs_pkg::RST_LOW_VOLTAGE_RESET_SELECT);
    rd(rcs_pkg::OFF_CTRL, ctrlM);
    rd(rcs_pkg::OFF_IRQ_STAT, irqM);
    apb(1'b1, rcs_pkg::OFF_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, rcs_pkg::OFF_IRQ_STAT, 32'h2);
    irqM = irqM & 8'hfd;
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rd(rcs_pkg::OFF_IRQ_STAT, irqM);
    // Short supply dip is ignored, a long one resets
    u_partner.supply_low(LVR_C - 1);
    quiet(12);
    u_partner.core_pulse(1'b0);
    u_partner.core_pulse(1'b1);
    statusM = (statusM & 8'hcf) | 8'h10;
    fork
      u_partner.supply_low(LVR_C + 4);
      await_reset(rcs_pkg::ACT_FULL, 1'b0);
    join
    ctrlM = (ctrlM & 8'h0f) | 8'h04;
    irqM = irqM | 8'h01;
    rd(rcs_pkg::OFF_STATUS, statusM);
    rd(rcs_pkg::OFF_CTRL, ctrlM);
    rd(rcs_pkg::OFF_IRQ_STAT, irqM);
    apb(1'b1, rcs_pkg::OFF_CTRL, 32'h0);
    rd(rcs_pkg::OFF_CTRL, 8'h00);
    // Watchdog switched off, then a bad enable code forces a full reset
    apb(1'b1, rcs_pkg::OFF_WATCHDOG_CONTROL, 32'hab);
    @(posedge clk);
    check({31'h0, wdtRun}, 32'h0);
    apb(1'b1, rcs_pkg::OFF_WATCHDOG_CONTROL, 32'h03);
    await_reset(rcs_pkg::ACT_FULL, 1'b0);
    check({31'h0, wdtRun}, 32'h1);
    irqM = irqM | 8'h08;
    rd(rcs_pkg::OFF_CTRL, 8'h01);
    rd(rcs_pkg::OFF_WATCHDOG_CONTROL, rcs_pkg::RST_WATCHDOG_CONTROL);
    rd(rcs_pkg::OFF_IRQ_STAT, irqM);
    rd(rcs_pkg::OFF_STATUS, statusM);
    // Undefined supply threshold code forces a full reset too
    apb(1'b1, rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT, 32'h12);
    await_reset(rcs_pkg::ACT_FULL, 1'b0);
    rd(rcs_pkg::OFF_CTRL, 8'h03);
    rd(rcs_pkg::OFF_LOW_VOLTAGE_RESET_SELECT, rcs_pkg::RST_LOW_VOLTAGE_RESET_SELECT);
    check({24'h0, lvrSelect}, {24'h0, rcs_pkg::RST_LOW_VOLTAGE_RESET_SELECT});
    rd(rcs_pkg::OFF_IRQ_STAT, irqM);
    complete_run();
  end
endmodule : reset_cause_state_control_bench
